// [design/cbm_supervisor.sv]
// Cell-balance measurement supervisor: scheduling, filtering control, halts and stop logic
//
// Summary of operation
// - Enable upper bit clear: no measurements
// - Enable upper bit set: measure during balancing
// - Code 11 adds UV check, not discharge
// - Enable field used only discharge/automated
// - Force 16x oversample, pyramid ordering
// - Scan writes while balancing rejected, alert
// - Automated measurements go through cell filter
// - No-filter coefficient replaced by one-eighth
// - Init clear keeps accumulators on entry
// - Init set loads first; check from 17th
// - Supervisory measurement after each even/odd pair
// - Calibration source follows apply and interval
// - Interval honoured only when measuring
// - Zero interval disables calibration
// - First cycle calibrates, then one per N
// - Inspect range alert after each conversion when applying calibration
// - Range alert halts balancing, skips cycles
// - Timer and hold continue after halt
// - Transfer strobe copies filter, deferred, reads zero
// - Strobe ignored outside automated or discharge balancing
// - Stop on expiry, UV, thermal, cal, rewrite
// - Manual switch suspend gated on CONV state, which manual mode never reaches
// - UV flags clear on disable or relaunch
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module cbm_supervisor
    import cbm_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // Register port
    input  wire logic [CBM_AW-1:0]     reg_addr,
    input  wire logic [CBM_DW-1:0]     reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [CBM_DW-1:0]     reg_rdata,
    // Balancing sequencer events
    input  wire logic                  pair_done,
    input  wire logic                  timer_expired,
    input  wire logic                  thermal_fault,
    input  wire logic [CBM_CELLS-1:0]  cell_below_uv,
    // Signal chain
    output logic                       conv_start,
    output logic                       conv_is_cal,
    input  wire logic                  conv_done,
    input  wire logic                  calibration_range_alert,
    output logic      [2:0]            oversample_count,
    output logic                       scan_ordering,
    output logic      [2:0]            filter_coefficient,
    output logic                       filter_enable,
    output logic                       filter_load_first,
    output logic                       use_fresh_cal,
    output logic                       use_factory_cal,
    output logic                       scan_transfer,
    output logic                       transfer_from_filter,
    // Balancing control
    output logic                       balance_active,
    output logic                       switch_suspend,
    output logic                       timer_run,
    output logic                       hold_allowed,
    output logic                       uv_check_active,
    output logic                       rejected_write_alert,
    output logic                       balance_calibration_alert
);

    typedef struct packed
    {
        logic [15:0]          ctrl;
        logic [15:0]          cfg;
        logic [2:0]           calibration_interval;
        logic [13:0]          balance_undervolt_threshold;
        logic [15:0]          scan_control_fields;
        cbm_state_e           state;
        logic                 active;
        logic                 halted;
        logic                 expired;
        logic                 xfer_pend;
        logic                 first_cycle;
        logic [5:0]           cal_cnt;
        logic [4:0]           meas_cnt;
        logic                 cur_cal;
        logic [CBM_CELLS-1:0] per_cell_undervolt_status;
        logic                 rjct;
        logic                 calalrt;
        logic                 start_p;
        logic                 cal_p;
        logic                 xfer_p;
        logic                 load_first;
        logic [15:0]          rdata;
    } cbm_state_s;

    cbm_state_s st_r;
    cbm_state_s st_nxt;

    cbm_mode_e  mode;
    logic [1:0] balance_measure_enable;
    logic       auto_mode;
    logic       disch_mode;
    logic       meas_on;
    logic       uv_on;
    logic       cal_on;
    logic       apply_calibration;
    logic       ctrl_wr;
    logic       ctrl_wr_start;
    logic       ctrl_wr_stop;
    logic       all_uv;

    assign mode                   = cbm_mode_e'(st_r.ctrl[CBM_MODE_LSB +: 3]);
    assign balance_measure_enable = st_r.ctrl[CBM_MEAS_LSB +: 2];
    assign apply_calibration      = st_r.cfg[CBM_CALEN_BIT];
    assign auto_mode              = mode[2];
    assign disch_mode             = (mode == CBM_MODE_DISCH);
    assign meas_on                = (auto_mode || disch_mode) && balance_measure_enable[1];
    assign uv_on                  = meas_on && auto_mode && (balance_measure_enable == 2'b11);
    assign cal_on                 = meas_on && (st_r.calibration_interval != 3'h0);
    assign ctrl_wr                = reg_wr && (reg_addr == CBM_REG_CTRL);
    assign ctrl_wr_stop           = ctrl_wr && (reg_wdata[CBM_MODE_LSB +: 3] == 3'h0);
    assign ctrl_wr_start          = ctrl_wr && !ctrl_wr_stop;
    assign all_uv                 = uv_on && (&(st_r.per_cell_undervolt_status | cell_below_uv));

    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.start_p = 1'b0;
        st_nxt.xfer_p  = 1'b0;
        st_nxt.rdata   = 16'h0000;

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                CBM_REG_CTRL:  st_nxt.ctrl = reg_wdata;
                CBM_REG_DLY:   st_nxt.calibration_interval = reg_wdata[2:0];
                CBM_REG_UVTHR: st_nxt.balance_undervolt_threshold = reg_wdata[13:0];
                CBM_REG_CFG:   st_nxt.cfg = reg_wdata;
                CBM_REG_SCAN:
                begin
                    if (st_r.active)
                        st_nxt.rjct = 1'b1;
                    else
                        st_nxt.scan_control_fields = reg_wdata;
                end
                CBM_REG_DATA:
                begin
                    if (reg_wdata[0] && st_r.active && (auto_mode || disch_mode))
                        st_nxt.xfer_pend = 1'b1;
                end
                CBM_REG_STATUS:
                begin
                    // Write one to clear alerts
                    if (reg_wdata[CBM_ST_RJCT])
                        st_nxt.rjct = 1'b0;
                    if (reg_wdata[CBM_ST_CALALRT])
                        st_nxt.calalrt = 1'b0;
                end
                default: ;
            endcase
        end

        // Any write of the mode field ends the current operation
        if (ctrl_wr)
        begin
            st_nxt.per_cell_undervolt_status = '0;
            st_nxt.halted      = 1'b0;
            st_nxt.expired     = 1'b0;
            st_nxt.xfer_pend   = 1'b0;
            st_nxt.state       = CBM_ST_IDLE;
            st_nxt.active      = ctrl_wr_start;
            st_nxt.first_cycle = 1'b1;
            st_nxt.cal_cnt     = 6'h00;
            st_nxt.meas_cnt    = 5'h00;
            st_nxt.load_first  = reg_wdata[CBM_IIRINIT_BIT];
        end
        else if (st_r.active)
        begin
            if (timer_expired)
            begin
                st_nxt.active  = 1'b0;
                st_nxt.expired = 1'b1;
            end
            // Init flag in CTRL, not load_first, which drops after the first sample
            if (uv_on && (st_r.meas_cnt >= CBM_SETTLE_CNT || !st_r.ctrl[CBM_IIRINIT_BIT]))
                st_nxt.per_cell_undervolt_status = st_r.per_cell_undervolt_status | cell_below_uv;
            if (all_uv && (&st_nxt.per_cell_undervolt_status))
                st_nxt.active = 1'b0;
            if ((auto_mode || disch_mode) && st_r.ctrl[CBM_TEMPEN_BIT] && thermal_fault)
                st_nxt.halted = 1'b1;

            case (st_r.state)
                CBM_ST_IDLE:
                begin
                    if (st_r.halted)
                        st_nxt.state = CBM_ST_HALTD;
                    else if (meas_on && (pair_done || st_r.first_cycle))
                    begin
                        st_nxt.cur_cal = cal_on && (st_r.first_cycle
                                         || (st_r.cal_cnt == cbm_cal_period(st_r.calibration_interval) - 6'h01));
                        st_nxt.cal_cnt = (cal_on && !st_r.first_cycle
                                         && st_r.cal_cnt != cbm_cal_period(st_r.calibration_interval) - 6'h01)
                                         ? st_r.cal_cnt + 6'h01 : 6'h00;
                        st_nxt.first_cycle = 1'b0;
                        st_nxt.start_p = 1'b1;
                        st_nxt.state   = CBM_ST_CONV;
                    end
                    else if (st_r.xfer_pend)
                        st_nxt.state = CBM_ST_XFER;
                end
                CBM_ST_CONV:
                begin
                    if (conv_done)
                    begin
                        if (apply_calibration && calibration_range_alert)
                        begin
                            st_nxt.calalrt = 1'b1;
                            st_nxt.halted  = 1'b1;
                            st_nxt.state   = CBM_ST_HALTD;
                        end
                        else
                        begin
                            if (!st_r.cur_cal)
                            begin
                                st_nxt.load_first = 1'b0;
                                if (st_r.meas_cnt != 5'h1F)
                                    st_nxt.meas_cnt = st_r.meas_cnt + 5'h01;
                            end
                            st_nxt.state = st_r.xfer_pend ? CBM_ST_XFER : CBM_ST_IDLE;
                        end
                    end
                end
                CBM_ST_XFER:
                begin
                    st_nxt.xfer_p    = 1'b1;
                    st_nxt.xfer_pend = 1'b0;
                    st_nxt.state     = CBM_ST_IDLE;
                end
                CBM_ST_HALTD:
                begin
                    // Skip all work; timer and hold run on outside
                    st_nxt.xfer_pend = 1'b0;
                end
                default: st_nxt.state = CBM_ST_IDLE;
            endcase
        end
        else
        begin
            st_nxt.state     = CBM_ST_IDLE;
            st_nxt.xfer_pend = 1'b0;
        end

        // Events that arrive with a clear still set the alerts
        if (st_r.active && reg_wr && reg_addr == CBM_REG_SCAN)
            st_nxt.rjct = 1'b1;
        if (st_r.state == CBM_ST_CONV && conv_done && apply_calibration && calibration_range_alert && !ctrl_wr)
            st_nxt.calalrt = 1'b1;

        // Read data, one cycle later
        if (reg_rd)
        begin
            case (reg_addr)
                CBM_REG_CTRL:   st_nxt.rdata = st_r.ctrl;
                CBM_REG_DLY:    st_nxt.rdata = {13'h0000, st_r.calibration_interval};
                CBM_REG_DATA:   st_nxt.rdata = 16'h0000;
                CBM_REG_UVTHR:  st_nxt.rdata = {2'h0, st_r.balance_undervolt_threshold};
                CBM_REG_SCAN:   st_nxt.rdata = st_r.scan_control_fields;
                CBM_REG_STATUS: st_nxt.rdata = {11'h000, st_r.xfer_pend, st_r.halted, st_r.active,
                                                st_r.rjct, st_r.calalrt};
                CBM_REG_UVSTAT: st_nxt.rdata = {2'h0, st_r.per_cell_undervolt_status};
                CBM_REG_CFG:    st_nxt.rdata = st_r.cfg;
                default:        st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_r                             <= '0;
            st_r.ctrl                        <= CBM_CTRL_RST;
            st_r.cfg                         <= CBM_CFG_RST;
            st_r.balance_undervolt_threshold <= CBM_UVTHR_RST;
            st_r.scan_control_fields         <= CBM_SCAN_RST;
            st_r.state                       <= CBM_ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata            = st_r.rdata;
    assign conv_start           = st_r.start_p;
    assign conv_is_cal          = st_r.cur_cal;
    assign oversample_count     = st_r.active ? CBM_OVS_16X : st_r.scan_control_fields[2:0];
    assign scan_ordering        = st_r.active ? CBM_ORDER_PYR : st_r.scan_control_fields[3];
    assign filter_enable        = st_r.active && (auto_mode || disch_mode);
    assign filter_coefficient   = (filter_enable && st_r.cfg[CBM_FC_LSB +: 3] == CBM_FC_NONE)
                                  ? CBM_FC_EIGHTH : st_r.cfg[CBM_FC_LSB +: 3];
    assign filter_load_first    = st_r.load_first && filter_enable;
    assign use_fresh_cal        = apply_calibration && cal_on;
    assign use_factory_cal      = !apply_calibration;
    assign scan_transfer        = st_r.xfer_p;
    assign transfer_from_filter = st_r.xfer_p;
    assign balance_active       = st_r.active && !st_r.halted;
    assign switch_suspend       = (mode == CBM_MODE_MANUAL) && st_r.cfg[CBM_SWSUSP_BIT]
                                  && st_r.state == CBM_ST_CONV;
    assign timer_run            = st_r.active;
    assign hold_allowed         = (st_r.active || st_r.expired) && (auto_mode || disch_mode)
                                  && st_r.ctrl[CBM_HOLD_LSB +: 2] != 2'h0;
    assign uv_check_active      = uv_on && (!st_r.ctrl[CBM_IIRINIT_BIT] || st_r.meas_cnt >= CBM_SETTLE_CNT);
    assign rejected_write_alert      = st_r.rjct;
    assign balance_calibration_alert = st_r.calalrt;

endmodule : cbm_supervisor

// [design/cbm_pkg.sv]
// Package for the cell-balance measurement supervisor: register map, fields, encodings
package cbm_pkg;
    localparam int          CBM_CELLS        = 14;
    localparam int          CBM_AW           = 4;
    localparam int          CBM_DW           = 16;
    // Register offsets
    localparam logic [3:0]  CBM_REG_CTRL     = 4'h0;
    localparam logic [3:0]  CBM_REG_DLY      = 4'h1;
    localparam logic [3:0]  CBM_REG_DATA     = 4'h2;
    localparam logic [3:0]  CBM_REG_UVTHR    = 4'h3;
    localparam logic [3:0]  CBM_REG_SCAN     = 4'h4;
    localparam logic [3:0]  CBM_REG_STATUS   = 4'h5;
    localparam logic [3:0]  CBM_REG_UVSTAT   = 4'h6;
    localparam logic [3:0]  CBM_REG_CFG      = 4'h7;
    // CTRL fields
    localparam int          CBM_MODE_LSB     = 0;
    localparam int          CBM_MEAS_LSB     = 3;
    localparam int          CBM_TEMPEN_BIT   = 5;
    localparam int          CBM_IIRINIT_BIT  = 6;
    localparam int          CBM_HOLD_LSB     = 7;
    // CFG fields
    localparam int          CBM_CALEN_BIT    = 0;
    localparam int          CBM_SWSUSP_BIT   = 1;
    localparam int          CBM_FC_LSB       = 2;
    // STATUS fields
    localparam int          CBM_ST_CALALRT   = 0;
    localparam int          CBM_ST_RJCT      = 1;
    localparam int          CBM_ST_ACTIVE    = 2;
    localparam int          CBM_ST_HALT      = 3;
    localparam int          CBM_ST_PEND      = 4;
    // Reset values
    localparam logic [15:0] CBM_CTRL_RST     = 16'h0000;
    localparam logic [15:0] CBM_CFG_RST      = 16'h001C;
    localparam logic [13:0] CBM_UVTHR_RST    = 14'h0000;
    localparam logic [15:0] CBM_SCAN_RST     = 16'h0000;
    // Fixed scan settings while balancing
    localparam logic [2:0]  CBM_OVS_16X      = 3'h4;
    localparam logic        CBM_ORDER_PYR    = 1'h1;
    localparam logic [2:0]  CBM_FC_NONE      = 3'h7;
    localparam logic [2:0]  CBM_FC_EIGHTH    = 3'h0;
    localparam logic [4:0]  CBM_SETTLE_CNT   = 5'h10;

    typedef enum logic [2:0]
    {
        CBM_MODE_OFF    = 3'b000,
        CBM_MODE_MANUAL = 3'b001,
        CBM_MODE_DISCH  = 3'b010,
        CBM_MODE_AIS    = 3'b100,
        CBM_MODE_AIM    = 3'b101,
        CBM_MODE_AGS    = 3'b110,
        CBM_MODE_AGM    = 3'b111
    } cbm_mode_e;

    typedef enum logic [2:0]
    {
        CBM_ST_IDLE  = 3'b000,
        CBM_ST_WAIT  = 3'b001,
        CBM_ST_CONV  = 3'b010,
        CBM_ST_XFER  = 3'b011,
        CBM_ST_HALTD = 3'b100
    } cbm_state_e;

    // Calibration interval code to period in cycles
    function automatic logic [5:0] cbm_cal_period(input logic [2:0] code);
        case (code)
            3'h1:    cbm_cal_period = 6'h02;
            3'h2:    cbm_cal_period = 6'h04;
            3'h3:    cbm_cal_period = 6'h08;
            3'h4:    cbm_cal_period = 6'h0C;
            3'h5:    cbm_cal_period = 6'h10;
            3'h6:    cbm_cal_period = 6'h18;
            3'h7:    cbm_cal_period = 6'h20;
            default: cbm_cal_period = 6'h00;
        endcase
    endfunction : cbm_cal_period
endpackage : cbm_pkg

// [bench/cbm_supervisor_props.sv]
// Concurrent checks on the ports of the balance measurement supervisor
`timescale 1ns/1ps
module cbm_supervisor_props
    import cbm_pkg::*;
(
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              rst_n,
    // Register port
    input wire logic [CBM_AW-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [CBM_DW-1:0] reg_rdata,
    // Signal chain and control
    input wire logic              conv_start,
    input wire logic [2:0]        oversample_count,
    input wire logic              scan_ordering,
    input wire logic [2:0]        filter_coefficient,
    input wire logic              filter_enable,
    input wire logic              scan_transfer,
    input wire logic              transfer_from_filter,
    input wire logic              balance_active,
    input wire logic              timer_run,
    input wire logic              rejected_write_alert,
    input wire logic              balance_calibration_alert
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside read answer");
    strobe_reads_zero_a: assert property (reg_rd && reg_addr == CBM_REG_DATA |=> reg_rdata == '0)
        else $error("transfer strobe register read not zero");
    forced_scan_a: assert property (balance_active |->
        oversample_count == CBM_OVS_16X && scan_ordering == CBM_ORDER_PYR)
        else $error("scan settings not forced while balancing");
    scan_reject_a: assert property (reg_wr && reg_addr == CBM_REG_SCAN && balance_active
        |=> rejected_write_alert)
        else $error("scan write while balancing not flagged");
    coef_subst_a: assert property (filter_enable |-> filter_coefficient != CBM_FC_NONE)
        else $error("filter enabled with no-filter coefficient");
    xfer_filter_a: assert property (scan_transfer |-> transfer_from_filter)
        else $error("transfer not taken from filter");
    xfer_active_a: assert property (scan_transfer |-> $past(balance_active))
        else $error("transfer outside balancing");
    cal_halt_a: assert property ($rose(balance_calibration_alert) |-> !conv_start [*8])
        else $error("conversion after calibration halt");
    halt_timer_a: assert property ($rose(balance_calibration_alert) |-> timer_run)
        else $error("timer stopped by calibration halt");
    conv_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");

    launch_c: cover property ($rose(balance_active) ##[1:4] conv_start);
    xfer_c: cover property (scan_transfer);
    halt_c: cover property ($rose(balance_calibration_alert));
endmodule : cbm_supervisor_props

bind cbm_supervisor cbm_supervisor_props u_props (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .conv_start, .oversample_count, .scan_ordering, .filter_coefficient, .filter_enable,
    .scan_transfer, .transfer_from_filter, .balance_active, .timer_run, .rejected_write_alert,
    .balance_calibration_alert);

// [bench/tb_cell_balance_measure_supervisor.sv]
// Register-level testbench for the balance measurement supervisor
`timescale 1ns/1ps
module tb_cell_balance_measure_supervisor;
    import cbm_pkg::*;
    logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pair_done = 0, timer_expired = 0;
    logic thermal_fault = 0, conv_done = 0, calibration_range_alert = 0;
    logic [CBM_AW-1:0] reg_addr = '0;
    logic [CBM_DW-1:0] reg_wdata = '0, reg_rdata;
    logic [CBM_CELLS-1:0] cell_below_uv = '0;
    logic [2:0] oversample_count, filter_coefficient;
    logic conv_start, conv_is_cal, scan_ordering, filter_enable, filter_load_first, use_fresh_cal;
    logic use_factory_cal, scan_transfer, transfer_from_filter, balance_active, switch_suspend;
    logic timer_run, hold_allowed, uv_check_active, rejected_write_alert, balance_calibration_alert;
    int num_errors = 0, cmp_count = 0;

    always #20 ref_clk = ~ref_clk;

    cbm_supervisor uut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pair_done, .timer_expired, .thermal_fault, .cell_below_uv, .conv_start, .conv_is_cal,
        .conv_done, .calibration_range_alert, .oversample_count, .scan_ordering, .filter_coefficient,
        .filter_enable, .filter_load_first, .use_fresh_cal, .use_factory_cal, .scan_transfer,
        .transfer_from_filter, .balance_active, .switch_suspend, .timer_run, .hold_allowed,
        .uv_check_active, .rejected_write_alert, .balance_calibration_alert);

    task final_report;
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd

    task pair;
        @(posedge ref_clk);
        pair_done <= 1'b1;
        @(posedge ref_clk);
        pair_done <= 1'b0;
    endtask : pair

    // Bounded wait for a conversion, then answer it; optional strobe while it runs
    task conv(input logic pres, input logic cal, input logic alrt, input logic xfer);
        logic seen;
        seen = 0;
        for (int n = 0; n < 12; n++)
        begin
            #1;
            if (conv_start === 1'b1)
            begin
                seen = 1;
                break;
            end
            @(posedge ref_clk);
        end
        chk("conv_start", pres, seen);
        if (pres && !seen)
            final_report();
        if (seen)
        begin
            chk("conv_is_cal", cal, conv_is_cal);
            if (xfer)
            begin
                wr(CBM_REG_DATA, 16'h0001);
                repeat (2)
                begin
                    #1;
                    chk("scan_transfer", 0, scan_transfer);
                    @(posedge ref_clk);
                end
            end
            else
                @(posedge ref_clk);
            conv_done <= 1'b1;
            calibration_range_alert <= alrt;
            @(posedge ref_clk);
            conv_done <= 1'b0;
            if (xfer)
            begin
                seen = 0;
                for (int n = 0; n < 6 && !seen; n++)
                begin
                    @(posedge ref_clk);
                    #1;
                    seen = (scan_transfer === 1'b1);
                end
                chk("deferred scan_transfer", 1, seen);
            end
        end
    endtask : conv

    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(CBM_REG_CTRL, CBM_CTRL_RST);
        rd(CBM_REG_CFG, CBM_CFG_RST);
        rd(CBM_REG_SCAN, CBM_SCAN_RST);
        rd(CBM_REG_DLY, 16'h0000);
        rd(CBM_REG_STATUS, 16'h0000);
        rd(4'hF, 16'h0000);
        chk("filter_coefficient", CBM_FC_NONE, filter_coefficient);
        wr(CBM_REG_SCAN, 16'h000B);
        wr(CBM_REG_DATA, 16'h0001);
        rd(CBM_REG_STATUS, 16'h0000);
        rd(CBM_REG_SCAN, 16'h000B);
        chk("oversample_count", 3'h3, oversample_count);
        // Interval codes 1 and 2: first conversion calibrates, then one per period
        for (int c = 1; c <= 2; c++)
        begin
            wr(CBM_REG_DLY, 16'(c));
            wr(CBM_REG_CTRL, 16'h0014);
            #1;
            chk("balance_active", 1, balance_active);
            chk("oversample_count", CBM_OVS_16X, oversample_count);
            chk("filter_coefficient", CBM_FC_EIGHTH, filter_coefficient);
            chk("filter_enable", 1, filter_enable);
            chk("use_factory_cal", 1, use_factory_cal);
            for (int i = 0; i <= (1 << c); i++)
            begin
                if (i > 0)
                    pair();
                conv(1, (i % (1 << c)) == 0, 0, 0);
            end
        end
        wr(CBM_REG_SCAN, 16'h0001);
        rd(CBM_REG_SCAN, 16'h000B);
        chk("rejected_write_alert", 1, rejected_write_alert);
        wr(CBM_REG_CTRL, 16'h0014);
        conv(1, 1, 0, 0);
        wr(CBM_REG_STATUS, 16'h0003);
        wr(CBM_REG_CTRL, 16'h0000);
        #1;
        chk("balance_active", 0, balance_active);
        chk("rejected_write_alert", 0, rejected_write_alert);
        // Measurement disabled: no conversions at all
        wr(CBM_REG_DLY, 16'h0001);
        wr(CBM_REG_CTRL, 16'h0004);
        conv(0, 0, 0, 0);
        pair();
        conv(0, 0, 0, 0);
        wr(CBM_REG_CTRL, 16'h001C);
        #1;
        chk("uv_check_active", 1, uv_check_active);
        wr(CBM_REG_CTRL, 16'h001A);
        #1;
        chk("uv_check_active disch", 0, uv_check_active);
        wr(CBM_REG_DLY, 16'h0000);
        wr(CBM_REG_CTRL, 16'h005C);
        #1;
        chk("filter_load_first", 1, filter_load_first);
        for (int i = 0; i < 16; i++)
        begin
            if (i > 0)
                pair();
            #1;
            chk("uv_check_active init", 0, uv_check_active);
            conv(1, 0, 0, 0);
        end
        #1;
        chk("uv_check_active 17th", 1, uv_check_active);
        wr(CBM_REG_CTRL, 16'h0000);
        wr(CBM_REG_CTRL, 16'h0014);
        conv(1, 0, 0, 1);
        rd(CBM_REG_DATA, 16'h0000);
        // Calibration fault halts, timer keeps running until expiry
        wr(CBM_REG_CTRL, 16'h0000);
        wr(CBM_REG_CFG, 16'h001D);
        wr(CBM_REG_CTRL, 16'h0194);
        #1;
        chk("use_fresh_cal", 0, use_fresh_cal);
        chk("use_factory_cal", 0, use_factory_cal);
        conv(1, 0, 1, 0);
        @(posedge ref_clk);
        calibration_range_alert <= 1'b0;
        #1;
        chk("balance_calibration_alert", 1, balance_calibration_alert);
        chk("timer_run", 1, timer_run);
        pair();
        conv(0, 0, 0, 0);
        @(posedge ref_clk);
        timer_expired <= 1'b1;
        @(posedge ref_clk);
        timer_expired <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("balance_active", 0, balance_active);
        chk("hold_allowed", 1, hold_allowed);
        wr(CBM_REG_STATUS, 16'h0003);
        #1;
        chk("balance_calibration_alert", 0, balance_calibration_alert);
        final_report();
    end
endmodule : tb_cell_balance_measure_supervisor
